// ==== hw/foc_classifier.sv ====
// Purpose: Float unit operand front end: classify, flush, NaN, disable
// Assumes: One operation issued per strobe, result checked on request
// Notes:   Register file has no reset; load before first use
// Function
// - Split sign, exponent and fraction fields
// - Exponent stored with bias 127 or 1023
// - Normal range valued as one-point-fraction
// - All-ones exponent gives infinity or nonnumber
// - Zero exponent gives zero or denormal
// - Fraction top bit set means signalling
// - Signalling input, enable clear: quiet result
// - Signalling input, enable set: trap, no write
// - Moves, abs, negate skip nonnumber handling
// - Quiet input alone: quiet result, no trap
// - Produced quiet result uses fixed pattern
// - Flush on: denormal arith operands become signed zero
// - Flush off: denormals kept as is
// - Unit disabled: instruction raises disable trap
// - 32 singles, also 16 double pairs
// - Round select 00 nearest, 01 zero
// - Flush off with denormal arith input: error
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module foc_classifier
    import foc_pkg::*;
#(
    parameter int NREG = NUM_SREGS
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Issue port from the pipeline
    input  wire logic        issue,
    input  wire foc_op_t     op,
    input  wire logic        dbl,
    input  wire logic        in_slot,
    input  wire logic        float_unit_disable,
    input  wire logic [4:0]  src_a,
    input  wire logic [4:0]  src_b,
    input  wire logic [4:0]  dst,
    // Register file load port
    input  wire logic        load,
    input  wire logic [4:0]  load_idx,
    input  wire logic [31:0] load_data,
    // Register access port
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // Results
    output logic             res_valid,
    output logic      [63:0] res_data,
    output logic             res_write,
    output logic      [63:0] opa_val,
    output logic      [63:0] opb_val,
    output foc_class_t       cls_a,
    output foc_class_t       cls_b,
    output logic      [10:0] exp_a,
    output logic      [51:0] frac_a,
    output logic             sign_a,
    output logic             round_zero,
    output logic             trap_general,
    output logic             trap_slot,
    output logic             trap_invalid,
    output logic             trap_error,
    output logic             irq
);
    // Singles, paired for doubles as {even, odd}
    logic [31:0] fregs [NREG];
    logic [2:0]  ctl_reg;
    logic [1:0]  round_reg;
    logic [2:0]  status_reg;
    logic [2:0]  mask_reg;
    logic [2:0]  ev_set;

    foc_dec_if ia();
    foc_dec_if ib();
    foc_decode u_da (.d(ia.dec));
    foc_decode u_db (.d(ib.dec));

    // Fetch operand from file; double takes an aligned pair
    function automatic logic [63:0] fetch(input logic [4:0] idx,
                                          input logic       is_dbl);
        logic [4:0] ev;
        ev = {idx[4:1], 1'b0};
        if (is_dbl)
            fetch = {fregs[ev], fregs[ev | 5'h1]};
        else
            fetch = {32'h0, fregs[idx]};
    endfunction

    // Signed zero with the operand's own sign
    function automatic logic [63:0] signed_zero(input logic s,
                                                input logic is_dbl);
        signed_zero = is_dbl ? {s, 63'h0} : {32'h0, s, 31'h0};
    endfunction

    assign ia.dbl = dbl;
    assign ib.dbl = dbl;
    // A plain assign would miss file writes read inside fetch
    always_comb begin
        ia.raw = fetch(src_a, dbl);
        ib.raw = fetch(src_b, dbl);
    end

    logic flush;
    logic inv_en;
    logic arith;
    logic any_signalling_nonnumber;
    logic any_quiet_nonnumber;
    logic any_den;
    logic disabled;
    logic [63:0] quiet_nonnumber_pat;
    logic [63:0] va;
    logic [63:0] vb;
    logic [63:0] result_next;
    logic        write_next;

    // Decision for one issued operation
    always_comb begin
        flush    = ctl_reg[CTL_BIT_FLUSH];
        inv_en   = ctl_reg[CTL_BIT_INVEN];
        arith    = (op == OP_ARITH);
        disabled = issue && float_unit_disable;
        // Non-arith ops never see nonnumber or denormal handling
        any_signalling_nonnumber = arith && (ia.cls.signalling_nonnumber || ib.cls.signalling_nonnumber);
        any_quiet_nonnumber = arith && (ia.cls.quiet_nonnumber || ib.cls.quiet_nonnumber);
        any_den  = arith && (ia.cls.denorm || ib.cls.denorm);
        quiet_nonnumber_pat = dbl ? DP_QUIET_NONNUMBER : {32'h0, SP_QUIET_NONNUMBER};
        va = ia.raw;
        vb = ib.raw;
        if (arith && flush && ia.cls.denorm)
            va = signed_zero(ia.sign, dbl);
        if (arith && flush && ib.cls.denorm)
            vb = signed_zero(ib.sign, dbl);
        // Flush off leaves denormals untouched in va and vb
        write_next  = 1'b1;
        result_next = va;
        case (op)
            OP_MOVE: result_next = ia.raw;
            OP_ABS:  result_next = dbl ? {1'b0, ia.raw[62:0]}
                                       : {32'h0, 1'b0, ia.raw[30:0]};
            OP_NEG:  result_next = dbl ? {~ia.raw[63], ia.raw[62:0]}
                                       : {32'h0, ~ia.raw[31], ia.raw[30:0]};
            default: begin
                if (any_signalling_nonnumber && inv_en)
                    write_next = 1'b0;
                else if (any_signalling_nonnumber || any_quiet_nonnumber)
                    result_next = quiet_nonnumber_pat;
                else if (!flush && any_den)
                    write_next = 1'b0;
            end
        endcase
        if (disabled)
            write_next = 1'b0;
    end

    // Event sources for the sticky status
    always_comb begin
        ev_set = '0;
        ev_set[ST_BIT_DIS] = disabled;
        ev_set[ST_BIT_INV] = issue && !disabled && any_signalling_nonnumber && inv_en;
        ev_set[ST_BIT_ERR] = issue && !disabled && !flush && any_den;
    end

    // Register file writes: load port, then results
    always_ff @(posedge clk) begin
        if (load)
            fregs[load_idx] <= load_data;
        if (issue && write_next) begin
            if (dbl) begin
                fregs[{dst[4:1], 1'b0}] <= result_next[63:32];
                fregs[{dst[4:1], 1'b1}] <= result_next[31:0];
            end else begin
                fregs[dst] <= result_next[31:0];
            end
        end
    end

    // Control: flush, invalid enable, round select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_reg   <= CTL_RESET;
            round_reg <= RND_NEAREST;
        end else if (wr && addr == OFS_CTL) begin
            ctl_reg   <= {1'b0, wdata[CTL_BIT_INVEN:0]};
            round_reg <= wdata[CTL_RND_LO +: 2];
        end
    end

    // Round toward zero only for code 01; others fall to nearest
    assign round_zero = (round_reg == RND_ZERO);

    // Sticky status, cleared by read; a new event wins the clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            status_reg <= ST_RESET;
        else if (rd && addr == OFS_STATUS)
            status_reg <= ev_set;
        else
            status_reg <= status_reg | ev_set;
    end

    // Interrupt mask
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            mask_reg <= MASK_RESET;
        else if (wr && addr == OFS_MASK)
            mask_reg <= wdata[2:0];
    end

    assign irq = |(status_reg & mask_reg);

    // Read data stands one cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0;
        end else if (rd) begin
            case (addr)
                OFS_CTL:    rdata <= {28'h0, round_reg, ctl_reg[1:0]};
                OFS_STATUS: rdata <= {29'h0, status_reg};
                OFS_MASK:   rdata <= {29'h0, mask_reg};
                OFS_CLASSA: rdata <= {26'h0, cls_a};
                OFS_CLASSB: rdata <= {26'h0, cls_b};
                default:    rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end

    // Registered decoded view, class and fields together
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cls_a  <= '0;
            cls_b  <= '0;
            exp_a  <= 11'h0;
            frac_a <= 52'h0;
            sign_a <= 1'b0;
            opa_val <= 64'h0;
            opb_val <= 64'h0;
        end else if (issue) begin
            cls_a  <= ia.cls;
            cls_b  <= ib.cls;
            exp_a  <= ia.exp;
            frac_a <= ia.frac;
            sign_a <= ia.sign;
            opa_val <= va;
            opb_val <= vb;
        end
    end

    // Result and trap pulses, one cycle after issue
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_valid    <= 1'b0;
            res_data     <= 64'h0;
            res_write    <= 1'b0;
            trap_general <= 1'b0;
            trap_slot    <= 1'b0;
            trap_invalid <= 1'b0;
            trap_error   <= 1'b0;
        end else begin
            res_valid    <= issue;
            res_data     <= issue ? result_next : 64'h0;
            res_write    <= issue && write_next;
            trap_general <= disabled && !in_slot;
            trap_slot    <= disabled && in_slot;
            trap_invalid <= ev_set[ST_BIT_INV];
            trap_error   <= ev_set[ST_BIT_ERR];
        end
    end

    // Checks: traps and results one cycle after the issue edge
    a_disable_trap: assert property (
        @(posedge clk) disable iff (rst)
        issue && float_unit_disable
        |=> (trap_general || trap_slot) && !res_write)
        else $error("disable trap missing");
    a_one_trap: assert property (
        @(posedge clk) disable iff (rst)
        !(trap_general && trap_slot))
        else $error("both disable traps raised");
    a_signalling_nonnumber_quiet: assert property (
        @(posedge clk) disable iff (rst)
        issue && op == OP_ARITH && !float_unit_disable && !ctl_reg[1]
            && (ia.cls.signalling_nonnumber || ib.cls.signalling_nonnumber)
        |=> res_data == $past(quiet_nonnumber_pat))
        else $error("quiet result missing");
    a_signalling_nonnumber_hold: assert property (
        @(posedge clk) disable iff (rst)
        issue && op == OP_ARITH && ctl_reg[1]
            && (ia.cls.signalling_nonnumber || ib.cls.signalling_nonnumber)
        |=> !res_write && (trap_invalid || trap_general || trap_slot))
        else $error("invalid trap missing");
    a_quiet_nonnumber_notrap: assert property (
        @(posedge clk) disable iff (rst)
        issue && op == OP_ARITH && !ia.cls.signalling_nonnumber && !ib.cls.signalling_nonnumber
            && ia.cls.quiet_nonnumber |=> !trap_invalid)
        else $error("quiet input trapped");
    // Produced quiet result is the fixed pattern, never the input
    a_quiet_nonnumber_fixed: assert property (
        @(posedge clk) disable iff (rst)
        issue && op == OP_ARITH && !float_unit_disable
            && !ia.cls.signalling_nonnumber && !ib.cls.signalling_nonnumber
            && (ia.cls.quiet_nonnumber || ib.cls.quiet_nonnumber)
        |=> res_write && res_data == ($past(dbl) ? DP_QUIET_NONNUMBER
                                                 : {32'h0, SP_QUIET_NONNUMBER}))
        else $error("quiet pattern wrong");
    a_move_plain: assert property (
        @(posedge clk) disable iff (rst)
        issue && op == OP_MOVE |=> !trap_invalid && !trap_error
            && res_data == $past(ia.raw))
        else $error("move altered");
    a_abs_sign: assert property (
        @(posedge clk) disable iff (rst)
        issue && op == OP_ABS
        |=> ($past(dbl) ? !res_data[63] : !res_data[31]) && !trap_invalid)
        else $error("absolute value kept sign");
    a_flush_zero: assert property (
        @(posedge clk) disable iff (rst)
        issue && op == OP_ARITH && ctl_reg[0] && ia.cls.denorm
        |=> opa_val[62:0] == 63'h0 || (!$past(dbl)
            && opa_val[30:0] == 31'h0))
        else $error("denormal not flushed");
    // Status is set on the trap edge; a later read may clear it
    a_denorm_err: assert property (
        @(posedge clk) disable iff (rst)
        issue && !float_unit_disable && op == OP_ARITH && !ctl_reg[0]
            && ib.cls.denorm |=> trap_error && status_reg[ST_BIT_ERR])
        else $error("denormal error missing");
    // Bounds reckoned from bias and minimum, not from field width
    a_norm_range: assert property (
        @(posedge clk) disable iff (rst)
        issue && ia.cls.norm
        |-> int'(ia.exp) - (dbl ? DP_BIAS : SP_BIAS)
                >= (dbl ? DP_EMIN : SP_EMIN)
            && int'(ia.exp) - (dbl ? DP_BIAS : SP_BIAS)
                <= (dbl ? DP_BIAS : SP_BIAS))
        else $error("normal exponent out of range");
    a_class_onehot: assert property (
        @(posedge clk) disable iff (rst)
        res_valid |-> $onehot(cls_a) && $onehot(cls_b))
        else $error("class not one-hot");
    // A clear by read never swallows an event of the same cycle
    a_status_set: assert property (
        @(posedge clk) disable iff (rst)
        |ev_set |=> (status_reg & $past(ev_set)) == $past(ev_set))
        else $error("status event lost");
    a_rdata_idle: assert property (
        @(posedge clk) disable iff (rst)
        !rd |=> rdata == 32'h0)
        else $error("read data outside read cycle");
    // Scenario covers
    c_signalling_nonnumber: cover property (@(posedge clk) trap_invalid);
    c_slot: cover property (@(posedge clk) trap_slot);
    c_flush: cover property (@(posedge clk)
        issue && ctl_reg[0] && ia.cls.denorm);
    c_dbl_quiet_nonnumber: cover property (@(posedge clk)
        res_valid && res_data == DP_QUIET_NONNUMBER);
    c_den_err: cover property (@(posedge clk) trap_error);
endmodule

// ==== hw/foc_decode.sv ====
// Purpose: Combinational split and classification of one operand
// Assumes: Single fraction left-aligned into 52 bits
// Notes:   Pure logic, registered by the caller
`timescale 1ns/1ps
module foc_decode
    import foc_pkg::*;
(
    // Operand and decoded view
    foc_dec_if.dec d
);
    logic fz;
    logic fmsb;

    // Split fields per precision
    always_comb begin
        if (d.dbl) begin
            d.sign = d.raw[63];
            d.exp  = d.raw[62:52];
            d.frac = d.raw[51:0];
            d.exp_ones = &d.raw[62:52];
        end else begin
            d.sign = d.raw[31];
            d.exp  = {3'h0, d.raw[30:23]};
            d.frac = {d.raw[22:0], 29'h0};
            d.exp_ones = &d.raw[30:23];
        end
    end

    // Classify: all-ones exp gives inf or nonnumber, zero exp gives
    // zero or denormal; sign never matters here
    always_comb begin
        fz   = (d.frac == 52'h0);
        fmsb = d.frac[51];
        d.cls = '0;
        if (d.exp_ones) begin
            d.cls.inf  = fz;
            d.cls.signalling_nonnumber = !fz && fmsb;
            d.cls.quiet_nonnumber = !fz && !fmsb;
        end else if (d.exp == 11'h0) begin
            d.cls.zero   = fz;
            d.cls.denorm = !fz;
        end else begin
            d.cls.norm = 1'b1;
        end
    end
endmodule

// ==== shared/foc_dec_if.sv ====
// Purpose: Carries one operand and its decoded view between modules
// Assumes: Single precision in bits 31:0
// Notes:   Decoder drives all decoded members
`timescale 1ns/1ps
interface foc_dec_if;
    import foc_pkg::*;
    logic        dbl;
    logic [63:0] raw;
    logic        sign;
    logic [10:0] exp;
    logic [51:0] frac;
    logic        exp_ones;
    foc_class_t  cls;
    modport src (output dbl, output raw,
                 input sign, input exp, input frac, input exp_ones,
                 input cls);
    modport dec (input dbl, input raw,
                 output sign, output exp, output frac, output exp_ones,
                 output cls);
endinterface

// ==== shared/foc_pkg.sv ====
// Purpose: Constants and types for the float operand classifier
// Assumes: IEEE-style single and double layouts
// Notes:   Operands travel as 64 bits; singles sit in the low word
package foc_pkg;
    // Field widths
    localparam int SP_EXP_W  = 8;
    localparam int SP_FRAC_W = 23;
    localparam int DP_EXP_W  = 11;
    localparam int DP_FRAC_W = 52;
    // Exponent biases and minimum true exponents
    localparam int SP_BIAS   = 127;
    localparam int DP_BIAS   = 1023;
    localparam int SP_EMIN   = -126;
    localparam int DP_EMIN   = -1022;
    // Default quiet results
    localparam logic [31:0] SP_QUIET_NONNUMBER = 32'h7FBFFFFF;
    localparam logic [63:0] DP_QUIET_NONNUMBER = 64'h7FF7FFFFFFFFFFFF;
    // Register file shape
    localparam int NUM_SREGS = 32;
    localparam int NUM_DREGS = 16;
    // Rounding select codes
    localparam logic [1:0] RND_NEAREST = 2'h0;
    localparam logic [1:0] RND_ZERO    = 2'h1;
    // Status register bit positions and reset values
    localparam int          ST_BIT_ERR   = 0;
    localparam int          ST_BIT_INV   = 1;
    localparam int          ST_BIT_DIS   = 2;
    localparam logic [2:0]  ST_RESET     = 3'h0;
    localparam logic [2:0]  MASK_RESET   = 3'h0;
    localparam logic [2:0]  CTL_RESET    = 3'h0;
    // Register offsets on the plain port
    localparam logic [3:0] OFS_CTL    = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_MASK   = 4'h2;
    localparam logic [3:0] OFS_CLASSA = 4'h3;
    localparam logic [3:0] OFS_CLASSB = 4'h4;
    // Control register fields
    localparam int CTL_BIT_FLUSH = 0;
    localparam int CTL_BIT_INVEN = 1;
    localparam int CTL_RND_LO    = 2;

    // One-hot class vector
    typedef struct packed {
        logic quiet_nonnumber;
        logic signalling_nonnumber;
        logic inf;
        logic norm;
        logic denorm;
        logic zero;
    } foc_class_t;

    // Operation kinds seen by the front end
    typedef enum logic [1:0] {
        OP_ARITH = 2'b00,
        OP_MOVE  = 2'b01,
        OP_ABS   = 2'b10,
        OP_NEG   = 2'b11
    } foc_op_t;
endpackage

// ==== verification/foc_pipe_model.sv ====
// Purpose: Pipeline side that issues float operations and loads
// Assumes: One issue or load per call, strobes one cycle long
// Notes:   Source B mirrors source A; destination fixed high
`timescale 1ns/1ps
module foc_pipe_model
    import foc_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Issue and load port
    output logic             issue,
    output foc_op_t          op,
    output logic             dbl,
    output logic             in_slot,
    output logic             float_unit_disable,
    output logic      [4:0]  src_a,
    output logic      [4:0]  src_b,
    output logic      [4:0]  dst,
    output logic             load,
    output logic      [4:0]  load_idx,
    output logic      [31:0] load_data
);
    // Idle from time zero so nothing is issued during reset
    initial begin
        issue = 1'b0;
        op = OP_MOVE;
        dbl = 1'b0;
        in_slot = 1'b0;
        float_unit_disable = 1'b0;
        src_a = 5'h00;
        src_b = 5'h00;
        dst = 5'h1E;
        load = 1'b0;
        load_idx = 5'h00;
        load_data = 32'h0;
    end

    // One operation; disable only held for its own issue cycle
    task automatic send(input foc_op_t o, input logic d, input logic s,
                        input logic dis, input logic [4:0] a);
        @(posedge clk);
        issue <= 1'b1;
        op <= o;
        dbl <= d;
        in_slot <= s;
        float_unit_disable <= dis;
        src_a <= a;
        src_b <= a;
        @(posedge clk);
        issue <= 1'b0;
        float_unit_disable <= 1'b0;
    endtask

    // Write one single register before it is used
    task automatic put(input logic [4:0] i, input logic [31:0] v);
        @(posedge clk);
        load <= 1'b1;
        load_idx <= i;
        load_data <= v;
        @(posedge clk);
        load <= 1'b0;
    endtask
endmodule

// ==== verification/fpu_operand_classifier_tb.sv ====
// Purpose: Self-checking bench for the float operand classifier
// Assumes: Mask bit set lets its status bit raise the interrupt
// Notes:   Outputs sampled 1 ns after the edge that answers
`timescale 1ns/1ps
module fpu_operand_classifier_tb;
    import foc_pkg::*;
    logic clk, rst, wr, rd, issue, dbl, in_slot, fdis, load;
    logic res_valid, res_write, sign_a, round_zero, irq;
    logic t_gen, t_slot, t_inv, t_err;
    logic [3:0] addr;
    logic [4:0] src_a, src_b, dst, load_idx;
    logic [10:0] exp_a;
    logic [31:0] wdata, rdata, load_data, rv;
    logic [51:0] frac_a;
    logic [63:0] res_data, opa_val, opb_val;
    foc_op_t op;
    foc_class_t cls_a, cls_b;
    int fails, checks, cycles;
    logic [31:0] tv [6] = '{32'h80000000, 32'h00000001, 32'h3F800000,
                            32'h7F800000, 32'h7FC00000, 32'h7F800001};

    foc_pipe_model u_pipe (.clk(clk), .issue(issue), .op(op), .dbl(dbl),
        .in_slot(in_slot), .float_unit_disable(fdis), .src_a(src_a),
        .src_b(src_b), .dst(dst), .load(load), .load_idx(load_idx),
        .load_data(load_data));

    foc_classifier u_dut (.clk(clk), .rst(rst), .issue(issue), .op(op),
        .dbl(dbl), .in_slot(in_slot), .float_unit_disable(fdis),
        .src_a(src_a), .src_b(src_b), .dst(dst), .load(load),
        .load_idx(load_idx), .load_data(load_data), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .res_valid(res_valid), .res_data(res_data), .res_write(res_write),
        .opa_val(opa_val), .opb_val(opb_val), .cls_a(cls_a), .cls_b(cls_b),
        .exp_a(exp_a), .frac_a(frac_a), .sign_a(sign_a),
        .round_zero(round_zero), .trap_general(t_gen), .trap_slot(t_slot),
        .trap_invalid(t_inv), .trap_error(t_err), .irq(irq));

    // 50 ns period
    always #25 clk = ~clk;

    // Hang guard; the sequence needs well under 1000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // Read data exists only in the cycle after the strobe
    task automatic rreg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask

    task automatic run(input foc_op_t o, input logic d, input logic [4:0] a);
        u_pipe.send(o, d, 1'b0, 1'b0, a);
        #1;
    endtask

    task automatic t_regs();
        rreg(OFS_CTL);
        chk(rv, 32'h0);
        rreg(OFS_MASK);
        chk(rv, 32'h0);
        wreg(OFS_CTL, 32'h4);
        chk(round_zero, 1'b1);
        wreg(OFS_CTL, 32'h0);
        chk(round_zero, 1'b0);
        wreg(4'hF, 32'h5);
        rreg(OFS_CTL);
        chk(rv, 32'h0);
        rreg(4'hF);
        chk(rv, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_class();
        for (int i = 0; i < 6; i++) begin
            u_pipe.put(5'h4, tv[i]);
            run(OP_MOVE, 1'b0, 5'h4);
            chk(64'(cls_a), 64'h1 << i);
            chk(exp_a, {3'h0, tv[i][30:23]});
            chk(frac_a, {tv[i][22:0], 29'h0});
            chk(sign_a, tv[i][31]);
        end
        $display("test class done");
    endtask

    task automatic t_nan();
        u_pipe.put(5'h4, tv[4]);
        run(OP_ARITH, 1'b0, 5'h4);
        chk({res_valid, res_write, t_inv}, 3'h6);
        chk(res_data, {32'h0, SP_QUIET_NONNUMBER});
        wreg(OFS_CTL, 32'h2);
        run(OP_ARITH, 1'b0, 5'h4);
        chk({res_write, t_inv}, 2'h1);
        for (int o = 1; o < 4; o++) begin
            run(foc_op_t'(o), 1'b0, 5'h4);
            chk({res_write, t_inv}, 2'h2);
        end
        run(OP_MOVE, 1'b0, 5'h4);
        chk(res_data, {32'h0, tv[4]});
        u_pipe.put(5'h4, tv[5]);
        run(OP_ARITH, 1'b0, 5'h4);
        chk({res_write, t_inv}, 2'h2);
        chk(res_data, {32'h0, SP_QUIET_NONNUMBER});
        wreg(OFS_CTL, 32'h0);
        u_pipe.put(5'h2, 32'h7FF80000);
        u_pipe.put(5'h3, 32'h0);
        run(OP_ARITH, 1'b1, 5'h2);
        chk(res_data, DP_QUIET_NONNUMBER);
        chk({exp_a, cls_a}, {11'h7FF, 6'h10});
        $display("test nan done");
    endtask

    task automatic t_flush();
        u_pipe.put(5'h6, 32'h80000001);
        wreg(OFS_CTL, 32'h1);
        run(OP_ARITH, 1'b0, 5'h6);
        chk(res_data, 64'h80000000);
        chk(opb_val, 64'h80000000);
        chk({res_write, t_err}, 2'h2);
        run(OP_NEG, 1'b0, 5'h6);
        chk(opa_val, 64'h80000001);
        wreg(OFS_CTL, 32'h0);
        run(OP_ARITH, 1'b0, 5'h6);
        chk({res_write, t_err}, 2'h1);
        chk(opa_val, 64'h80000001);
        u_pipe.put(5'h6, tv[2]);
        run(OP_ARITH, 1'b0, 5'h6);
        chk({res_write, t_err}, 2'h2);
        chk(res_data, {32'h0, tv[2]});
        $display("test flush done");
    endtask

    task automatic t_dis();
        rreg(OFS_STATUS);
        for (int s = 0; s < 2; s++) begin
            u_pipe.send(OP_ARITH, 1'b0, s[0], 1'b1, 5'h6);
            #1;
            chk({t_gen, t_slot, res_write}, s ? 3'h2 : 3'h4);
        end
        rreg(OFS_STATUS);
        chk(rv, 32'h4);
        $display("test disable done");
    endtask

    task automatic t_irq();
        wreg(OFS_CTL, 32'h2);
        u_pipe.put(5'h4, tv[4]);
        run(OP_ARITH, 1'b0, 5'h4);
        chk(irq, 1'b0);
        wreg(OFS_MASK, 32'h7);
        chk(irq, 1'b1);
        wreg(OFS_MASK, 32'h0);
        chk(irq, 1'b0);
        wreg(OFS_MASK, 32'h7);
        rreg(OFS_STATUS);
        chk(rv, 32'h2);
        chk(irq, 1'b0);
        $display("test irq done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        addr = 4'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        fails = 0;
        checks = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_class();
        t_nan();
        t_flush();
        t_dis();
        t_irq();
        report_and_stop();
    end
endmodule
